/* src/watchdog_timer_reset_monitor.sv */
`timescale 1ns/1ns
module watchdog_timer_reset_monitor
#(
   parameter int TIMER_W = 14
)
(
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        idleMode,
   input  wire logic [watchdog_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [watchdog_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output logic                             resetRequest
);
   import watchdog_pkg::*;

   // ---------------------------------------------------------------
   // prescaler decode
   // ---------------------------------------------------------------
   function automatic logic [7:0] prescaleLast(input logic [2:0] sel);
      logic [7:0] r;
      r = 8'h01;
      case (sel)
         3'h0:    r = 8'h01;
         3'h2:    r = 8'h03;
         3'h1:    r = 8'h07;
         3'h3:    r = 8'h0F;
         3'h4:    r = 8'h1F;
         3'h5:    r = 8'h3F;
         3'h6:    r = 8'h7F;
         3'h7:    r = 8'hFF;
         default: r = 8'h01;
      endcase
      return r;
   endfunction : prescaleLast

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   watchdog_control_s ctrl_reg;
   wd_state_e         state_reg;
   logic [3:0]        machine_reg;
   logic [7:0]        prescale_reg;
   logic [TIMER_W-1:0] timer_reg;
   logic [4:0]        hold_reg;
   logic              awHeld_reg;
   logic              wHeld_reg;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [31:0]       wData_reg;
   logic [3:0]        wStrb_reg;

   wire machineTick = (machine_reg == MACHINE_LAST);
   wire running     = ctrl_reg.runEnable && (!idleMode || ctrl_reg.idleRunAllow)
                      && (state_reg == ST_RUN);
   wire [7:0] preLast = prescaleLast(ctrl_reg.prescaleSelect);
   wire preTick     = running && machineTick && (prescale_reg >= preLast);
   wire timeout     = preTick && (timer_reg == TIMER_W'(TIMER_MAX));
   wire clearNow    = ctrl_reg.clearRequest && machineTick;
   wire firing      = (state_reg == ST_FIRE);
   wire holdDone    = (hold_reg == HOLD_LAST);

   wire awTake  = s_axi_awvalid && s_axi_awready;
   wire wTake   = s_axi_wvalid && s_axi_wready;
   wire arTake  = s_axi_arvalid && s_axi_arready;
   wire doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   wire wrCtrl  = doWrite && (awAddr_reg == OFF_WATCHDOG_CONTROL) && wStrb_reg[0];
   wire wrMapped = (awAddr_reg == OFF_WATCHDOG_CONTROL) || (awAddr_reg == OFF_WATCHDOG_COUNT);
   wire rdCtrl  = (s_axi_araddr == OFF_WATCHDOG_CONTROL);
   wire rdCount = (s_axi_araddr == OFF_WATCHDOG_COUNT);
   wire [31:0] rdData = rdCtrl  ? {24'h000000, ctrl_reg & 8'hE7} :
                        rdCount ? {{(32 - TIMER_W){1'b0}}, timer_reg} : 32'h00000000;

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   watchdog_control_s ctrl_next;
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (clearNow)
         ctrl_next.clearRequest = 1'b0;
      if (wrCtrl)
      begin
         ctrl_next.runEnable      = wData_reg[RUN_ENABLE_BIT];
         ctrl_next.idleRunAllow   = wData_reg[IDLE_RUN_BIT];
         ctrl_next.prescaleSelect = wData_reg[PRESCALE_LSB +: 3];
         if (wData_reg[CLEAR_REQUEST_BIT])
            ctrl_next.clearRequest = 1'b1;
      end
      ctrl_next.spare = 2'b00;
      if (firing)
         ctrl_next = CONTROL_RESET;
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         ctrl_reg <= CONTROL_RESET;
      else
         ctrl_reg <= ctrl_next;
   end

   // ---------------------------------------------------------------
   // divider chain
   // ---------------------------------------------------------------
   wire [3:0]  machineNext  = machineTick ? 4'h0 : machine_reg + 4'h1;
   wire [7:0]  prescaleNext = (clearNow || firing) ? PRESCALE_RESET :
                              preTick ? PRESCALE_RESET :
                              (running && machineTick) ? prescale_reg + 8'h01 :
                              prescale_reg;
   wire [TIMER_W-1:0] timerNext = (clearNow || firing) ? TIMER_W'(COUNT_RESET) :
                              preTick ? timer_reg + TIMER_W'(1) :
                              timer_reg;

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         machine_reg  <= 4'h0;
         prescale_reg <= PRESCALE_RESET;
         timer_reg    <= TIMER_W'(COUNT_RESET);
      end
      else
      begin
         machine_reg  <= machineNext;
         prescale_reg <= prescaleNext;
         timer_reg    <= timerNext;
      end
   end

   // ---------------------------------------------------------------
   // reset request
   // ---------------------------------------------------------------
   wd_state_e state_next;
   always_comb
   begin
      case (state_reg)
         ST_RUN:  state_next = timeout ? ST_FIRE : ST_RUN;
         ST_FIRE: state_next = holdDone ? ST_RUN : ST_FIRE;
         default: state_next = ST_RUN;
      endcase
   end

   wire [4:0] holdNext = firing ? hold_reg + 5'h01 : 5'h00;

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_reg    <= ST_RUN;
         hold_reg     <= 5'h00;
         resetRequest <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         hold_reg     <= holdNext;
         resetRequest <= (state_next == ST_FIRE);
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite write
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awHeld_reg    <= 1'b0;
         wHeld_reg     <= 1'b0;
         awAddr_reg    <= '0;
         wData_reg     <= 32'h00000000;
         wStrb_reg     <= 4'h0;
      end
      else
      begin
         s_axi_awready <= s_axi_awvalid && !awHeld_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= s_axi_wvalid && !wHeld_reg && !s_axi_wready && !s_axi_bvalid;
         if (awTake)
         begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (wTake)
         begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            awHeld_reg   <= 1'b0;
            wHeld_reg    <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (arTake)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdData;
            s_axi_rresp  <= (rdCtrl || rdCount) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence clearTaken;
      ctrl_reg.clearRequest && machineTick && !firing;
   endsequence

   sequence counterZeroed;
      (timer_reg == TIMER_W'(COUNT_RESET)) && (prescale_reg == PRESCALE_RESET);
   endsequence

   machine_range_a: assert property (machine_reg <= MACHINE_LAST)
      else $error("machine divider out of range");

   fire_cause_a: assert property ($rose(resetRequest) |-> $past(ctrl_reg.runEnable)
      && $past(timer_reg) == TIMER_W'(TIMER_MAX))
      else $error("reset request without enabled overflow");

   off_frozen_a: assert property (!ctrl_reg.runEnable && !ctrl_reg.clearRequest
      |=> $stable(timer_reg))
      else $error("timer moved while disabled");

   clear_effect_a: assert property (clearTaken |=> counterZeroed)
      else $error("clear did not zero counters");

   clear_self_a: assert property ($rose(ctrl_reg.clearRequest) && !wrCtrl
      |-> ##[1:12] !ctrl_reg.clearRequest)
      else $error("clear request stuck");

   idle_stop_a: assert property (idleMode && !ctrl_reg.idleRunAllow && !ctrl_reg.clearRequest
      |=> $stable(timer_reg))
      else $error("timer ran in idle");

   timer_step_a: assert property (preTick && !clearNow && !timeout
      |=> timer_reg == $past(timer_reg) + TIMER_W'(1) && prescale_reg == 8'h00)
      else $error("timer did not step on prescaler pulse");

   prescale_wrap_a: assert property (running && machineTick && !clearNow
      && ctrl_reg.prescaleSelect == 3'h2 && prescale_reg == 8'h02
      |=> prescale_reg == 8'h03)
      else $error("prescaler ratio wrong");

   hold_length_a: assert property ($fell(resetRequest) |-> $past(hold_reg) == HOLD_LAST
      && ctrl_reg == CONTROL_RESET)
      else $error("reset request length or control clear wrong");

   hold_bound_a: assert property (resetRequest |-> hold_reg <= HOLD_LAST)
      else $error("reset request too long");

endmodule : watchdog_timer_reset_monitor

/* src/watchdog_pkg.sv */
package watchdog_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [3:0]  OFF_WATCHDOG_CONTROL = 4'h0;
   localparam logic [3:0]  OFF_WATCHDOG_COUNT   = 4'h4;
   localparam int          ADDR_W               = 4;
   localparam logic [7:0]  CONTROL_RESET        = 8'h00;
   localparam logic [13:0] COUNT_RESET          = 14'h0000;
   localparam logic [7:0]  PRESCALE_RESET       = 8'h00;
   localparam logic [1:0]  RESP_OKAY            = 2'h0;
   localparam logic [1:0]  RESP_SLVERR          = 2'h2;

   // ---------------------------------------------------------------
   // control field positions
   // ---------------------------------------------------------------
   localparam int RUN_ENABLE_BIT    = 7;
   localparam int CLEAR_REQUEST_BIT = 6;
   localparam int IDLE_RUN_BIT      = 5;
   localparam int PRESCALE_LSB      = 0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          MACHINE_DIV     = 12;
   localparam int          HOLD_MACHINES   = 2;
   localparam int          RESET_HOLD_NS   = HOLD_MACHINES * MACHINE_DIV * CLK_PERIOD_NS;
   localparam int          RESET_HOLD_CYC  = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  MACHINE_LAST    = 4'(MACHINE_DIV - 1);
   localparam logic [4:0]  HOLD_LAST       = 5'(RESET_HOLD_CYC - 1);
   localparam logic [13:0] TIMER_MAX       = 14'h3FFF;

   typedef struct packed {
      logic       runEnable;
      logic       clearRequest;
      logic       idleRunAllow;
      logic [1:0] spare;
      logic [2:0] prescaleSelect;
   } watchdog_control_s;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_FIRE = 2'b10
   } wd_state_e;
endpackage : watchdog_pkg

/* bench/watchdog_timer_reset_monitor_test.sv */
`timescale 1ns/1ns
module watchdog_timer_reset_monitor_test;
   import watchdog_pkg::*;
   // short timer keeps the run brief; the time-out scales as 2^TIMER_W
   localparam int TIMER_W = 10;
   localparam int PERIOD  = MACHINE_DIV * 2 * (2 ** TIMER_W);
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic              ref_clk     = 1'b0;
   logic              sys_rst     = 1'b1;
   logic              idleMode    = 1'b0;
   logic [ADDR_W-1:0] awAddr      = '0;
   logic              awValid     = 1'b0;
   logic              awReady;
   logic [31:0]       wData       = '0;
   logic [3:0]        wStrb       = '0;
   logic              wValid      = 1'b0;
   logic              wReady;
   logic [1:0]        bResp;
   logic              bValid;
   logic              bReady      = 1'b0;
   logic [ADDR_W-1:0] arAddr      = '0;
   logic              arValid     = 1'b0;
   logic              arReady;
   logic [31:0]       rData;
   logic [1:0]        rResp;
   logic              rValid;
   logic              rReady      = 1'b0;
   logic              resetRequest;
   int                n_mismatch  = 0;
   int                checks_done = 0;
   int                ratioOf [8] = '{2, 8, 4, 16, 32, 64, 128, 256};
   logic [31:0]       data;
   logic [31:0]       prev;
   logic [1:0]        resp;
   int                i;
   int                expCount;

   watchdog_timer_reset_monitor #(.TIMER_W(TIMER_W)) dut
   (
      .ref_clk       (ref_clk),
      .sys_rst       (sys_rst),
      .idleMode      (idleMode),
      .s_axi_awaddr  (awAddr),
      .s_axi_awvalid (awValid),
      .s_axi_awready (awReady),
      .s_axi_wdata   (wData),
      .s_axi_wstrb   (wStrb),
      .s_axi_wvalid  (wValid),
      .s_axi_wready  (wReady),
      .s_axi_bresp   (bResp),
      .s_axi_bvalid  (bValid),
      .s_axi_bready  (bReady),
      .s_axi_araddr  (arAddr),
      .s_axi_arvalid (arValid),
      .s_axi_arready (arReady),
      .s_axi_rdata   (rData),
      .s_axi_rresp   (rResp),
      .s_axi_rvalid  (rValid),
      .s_axi_rready  (rReady),
      .resetRequest  (resetRequest)
   );

   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
      checks_done++;
      if (seen !== expected)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, expected);
      end
   endtask : check

   task automatic hang(input int n);
      if (n >= 100)
      begin
         n_mismatch++;
         $display("[FAIL] %0t bus wait ran out", $time);
         finish_test();
      end
   endtask : hang

   task automatic axiWrite(input logic [3:0] addr, input logic [7:0] val, input logic [3:0] strb,
                           output logic [1:0] r);
      logic awDone;
      logic wDone;
      int   n;
      awDone = 1'b0;
      wDone = 1'b0;
      @(posedge ref_clk);
      awAddr  <= addr;
      awValid <= 1'b1;
      wData   <= {24'h000000, val};
      wStrb   <= strb;
      wValid  <= 1'b1;
      bReady  <= 1'b1;
      for (n = 0; n < 100 && !(awDone && wDone); n++)
      begin
         @(posedge ref_clk);
         if (awReady === 1'b1 && !awDone)
         begin
            awDone = 1'b1;
            awValid <= 1'b0;
         end
         if (wReady === 1'b1 && !wDone)
         begin
            wDone = 1'b1;
            wValid <= 1'b0;
         end
      end
      hang(n);
      for (n = 0; n < 100 && bValid !== 1'b1; n++)
         @(posedge ref_clk);
      hang(n);
      r = bResp;
      bReady <= 1'b0;
   endtask : axiWrite

   task automatic axiRead(input logic [3:0] addr, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge ref_clk);
      arAddr  <= addr;
      arValid <= 1'b1;
      rReady  <= 1'b1;
      for (n = 0; n < 100 && arReady !== 1'b1; n++)
         @(posedge ref_clk);
      hang(n);
      arValid <= 1'b0;
      for (n = 0; n < 100 && rValid !== 1'b1; n++)
         @(posedge ref_clk);
      hang(n);
      d = rData;
      r = rResp;
      rReady <= 1'b0;
   endtask : axiRead

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      axiRead(OFF_WATCHDOG_CONTROL, data, resp);
      check(data, 32'h00000000, "control after reset");
      check(resp, RESP_OKAY, "control read resp");
      repeat (300) @(posedge ref_clk);
      axiRead(OFF_WATCHDOG_COUNT, data, resp);
      check(data, 32'h00000000, "count while disabled");
      axiWrite(OFF_WATCHDOG_CONTROL, 8'h80, 4'hE, resp);
      check(resp, RESP_OKAY, "masked write resp");
      axiWrite(OFF_WATCHDOG_COUNT, 8'h55, 4'hF, resp);
      check(resp, RESP_OKAY, "count write resp");
      axiRead(OFF_WATCHDOG_CONTROL, data, resp);
      check(data, 32'h00000000, "ignored writes");
      axiRead(4'h8, data, resp);
      check(resp, RESP_SLVERR, "unmapped read");
      axiWrite(4'hC, 8'h80, 4'hF, resp);
      check(resp, RESP_SLVERR, "unmapped write");
      axiWrite(OFF_WATCHDOG_CONTROL, 8'h7F, 4'hF, resp);
      repeat (20) @(posedge ref_clk);
      axiRead(OFF_WATCHDOG_CONTROL, data, resp);
      check(data, 32'h00000027, "clear bit self clears");
      for (int s = 0; s < 8; s++)
      begin
         axiWrite(OFF_WATCHDOG_CONTROL, 8'hC0 | 8'(s), 4'hF, resp);
         repeat (6144) @(posedge ref_clk);
         axiRead(OFF_WATCHDOG_COUNT, data, resp);
         expCount = 6144 / (12 * ratioOf[s]);
         check(32'(data + 1 >= expCount && data <= expCount + 1), 32'h1, "rate");
      end
      axiWrite(OFF_WATCHDOG_CONTROL, 8'h80, 4'hF, resp);
      repeat (2400) @(posedge ref_clk);
      axiWrite(OFF_WATCHDOG_CONTROL, 8'hC0, 4'hF, resp);
      repeat (13) @(posedge ref_clk);
      axiRead(OFF_WATCHDOG_COUNT, data, resp);
      check(32'(data <= 1), 32'h1, "count after clear");
      idleMode <= 1'b1;
      axiRead(OFF_WATCHDOG_COUNT, prev, resp);
      repeat (480) @(posedge ref_clk);
      axiRead(OFF_WATCHDOG_COUNT, data, resp);
      check(data, prev, "idle stops count");
      axiWrite(OFF_WATCHDOG_CONTROL, 8'hA0, 4'hF, resp);
      repeat (480) @(posedge ref_clk);
      axiRead(OFF_WATCHDOG_COUNT, data, resp);
      check(32'(data >= prev + 15), 32'h1, "idle run counts");
      idleMode <= 1'b0;
      axiWrite(OFF_WATCHDOG_CONTROL, 8'hC0, 4'hF, resp);
      for (i = 0; i < PERIOD + 100 && resetRequest !== 1'b1; i++)
         @(posedge ref_clk);
      check(32'(i > PERIOD && i <= PERIOD + MACHINE_DIV), 32'h1, "time-out period");
      for (i = 0; i < 100 && resetRequest === 1'b1; i++)
         @(posedge ref_clk);
      check(i, RESET_HOLD_CYC, "reset request length");
      axiRead(OFF_WATCHDOG_CONTROL, data, resp);
      check(data, 32'h00000000, "control after time-out");
      repeat (2000) @(posedge ref_clk);
      axiRead(OFF_WATCHDOG_COUNT, data, resp);
      check(data, 32'h00000000, "count after time-out");
      check(resetRequest, 1'b0, "no second request");
      finish_test();
   end
endmodule : watchdog_timer_reset_monitor_test
